/* File: common/uptd_map.vh */
// register-free constant map for the uart protocol trigger decoder
`ifndef UPTD_MAP_VH
`define UPTD_MAP_VH
`define UPTD_CLK_HZ 250000000
`define UPTD_RATE_MIN 150
`define UPTD_RATE_MAX 39062500
`define UPTD_DIV_W 24
`define UPTD_DIV_RESET 24'h00D904
`define UPTD_MODE_START 4'h0
`define UPTD_MODE_FRAME 4'h1
`define UPTD_MODE_FERR 4'h2
`define UPTD_MODE_SYMBOL 4'h3
`define UPTD_MODE_BREAK 4'h4
`define UPTD_MODE_PERR 4'h5
`define UPTD_MODE_PATTERN 4'h6
`define UPTD_MODE_ANY 4'h7
`define UPTD_PAR_NONE 2'h0
`define UPTD_PAR_EVEN 2'h1
`define UPTD_PAR_ODD 2'h2
`define UPTD_STOP_1 2'h0
`define UPTD_STOP_15 2'h1
`define UPTD_STOP_2 2'h2
`define UPTD_PRESET_COUNT 8
`define UPTD_OFFSET_MAX 12'hFFF
`endif

/* File: rtl/uptd_decoder.v */
// uart protocol decoder with trigger unit, one clock, plain config ports
`timescale 1ns/1ps
`include "uptd_map.vh"

// Notes on behaviour
// - symbol: start, data, optional parity, stop bits
// - start bit is logic zero after polarity
// - stop bits and idle are logic one
// - consecutive symbols grouped; gap ends the frame
// - sampling aligned by start/stop and rate
// - polarity selects level meaning one, both lines
// - no parity: data straight to stop
// - even parity: total ones even
// - odd parity: total ones odd
// - stop length one, one and half; two waits only one stop bit before hunting
// - user rate 150 to 39062500 bit/s
// - preset rates 300 bit/s to 1 Mbit/s
// - data bits five to nine
// - idle time sets minimum inter-frame gap
// - start-bit mode and frame-start mode triggers
// - break fires when stop bit missing and low outlasts a whole symbol
// - parity error and break separate conditions
// - pattern of 1-4 symbols at offset
// - any-symbol matches single pattern anywhere
// - rx and tx inputs, selectable source
// - pattern offset 0 to 4095 symbols
// - don't-care bits; all-x nibble ignored
// - break: zero longer than one symbol
// - symbol mode fires on n-th symbol
module uptd_decoder #(
  parameter DIV_W = `UPTD_DIV_W,
  parameter IDLE_W = 24
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // observed lines
  input wire rx_line,
  input wire tx_line,
  input wire tx_used,
  input wire source_tx,
  // line format
  input wire polarity_low,
  input wire [1:0] parity_mode,
  input wire [1:0] stop_mode,
  input wire [3:0] data_bits,
  // bit rate
  input wire rate_user,
  input wire [DIV_W-1:0] user_div,
  input wire [2:0] preset_sel,
  input wire [IDLE_W-1:0] idle_cycles,
  // trigger setup
  input wire [3:0] trig_mode,
  input wire [11:0] sym_offset,
  input wire [2:0] pat_len,
  input wire [35:0] pat_value,
  input wire [35:0] pat_care,
  // decoded symbol stream
  output reg [8:0] sym_data,
  output reg sym_perr,
  output reg sym_ferr,
  output reg sym_first,
  output wire sym_valid,
  input wire sym_ready,
  // events
  output reg trigger,
  output reg break_seen,
  output reg frame_active,
  output wire rate_error
);
  // receiver states
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_BRK = 3'h5;

  // preset dividers, 300 bit/s up to 1 Mbit/s at the core rate
  function [DIV_W-1:0] preset_div;
    input [2:0] sel;
    reg [31:0] full;
    begin
      case (sel)
        3'h0: full = `UPTD_CLK_HZ / 300;
        3'h1: full = `UPTD_CLK_HZ / 1200;
        3'h2: full = `UPTD_CLK_HZ / 2400;
        3'h3: full = `UPTD_CLK_HZ / 9600;
        3'h4: full = `UPTD_CLK_HZ / 19200;
        3'h5: full = `UPTD_CLK_HZ / 115200;
        3'h6: full = `UPTD_CLK_HZ / 500000;
        default: full = `UPTD_CLK_HZ / 1000000;
      endcase
      // every preset divider fits the counter width
      preset_div = full[DIV_W-1:0];
    end
  endfunction

  // cycles per bit, limits of user rate in cycles
  localparam [31:0] DIV_MAX_FULL = `UPTD_CLK_HZ / `UPTD_RATE_MIN;
  localparam [31:0] DIV_MIN_FULL = `UPTD_CLK_HZ / `UPTD_RATE_MAX;
  localparam [DIV_W-1:0] DIV_MAX = DIV_MAX_FULL[DIV_W-1:0];
  localparam [DIV_W-1:0] DIV_MIN = DIV_MIN_FULL[DIV_W-1:0];
  wire [DIV_W-1:0] bit_div = rate_user ? user_div : preset_div(preset_sel);
  // out-of-range user rate is flagged and receiver held idle
  assign rate_error = rate_user && (user_div < DIV_MIN || user_div > DIV_MAX);

  // line select and polarity, both lines share one polarity
  wire raw_line = (source_tx && tx_used) ? tx_line : rx_line;
  wire line = raw_line ^ polarity_low;
  wire [3:0] nbits = (data_bits < 4'h5) ? 4'h5 : ((data_bits > 4'h9) ? 4'h9 : data_bits);

  // receiver state
  reg [2:0] state;
  reg [DIV_W-1:0] bit_cnt;
  reg [3:0] bit_idx;
  reg [8:0] shift;
  reg par_acc;
  reg perr;
  reg [IDLE_W-1:0] gap_cnt;
  reg in_frame;
  reg [12:0] sym_idx;
  reg [DIV_W+3:0] low_cnt;
  // half and one and a half bit positions
  wire [DIV_W-1:0] half_div = {1'b0, bit_div[DIV_W-1:1]};
  wire [DIV_W-1:0] stop_len = (stop_mode == `UPTD_STOP_15) ? bit_div + half_div : bit_div;
  // one symbol: start, data, parity, stop, in cycles
  wire [3:0] sym_bits = 4'h2 + nbits + ((parity_mode == `UPTD_PAR_NONE) ? 4'h0 : 4'h1);
  wire [DIV_W+3:0] sym_cycles = bit_div * sym_bits;

  // symbol completion pulse, shared by stream and triggers
  reg done;
  reg [8:0] done_data;
  reg done_perr;
  reg done_ferr;
  reg done_first;
  reg start_ev;
  reg frame_ev;
  reg break_ev;

  // receiver: samples mid-bit from the falling start edge
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      bit_cnt <= {DIV_W{1'b0}};
      bit_idx <= 4'h0;
      shift <= 9'h000;
      par_acc <= 1'b0;
      perr <= 1'b0;
      gap_cnt <= {IDLE_W{1'b0}};
      in_frame <= 1'b0;
      done <= 1'b0;
      done_data <= 9'h000;
      done_perr <= 1'b0;
      done_ferr <= 1'b0;
      done_first <= 1'b0;
      start_ev <= 1'b0;
      frame_ev <= 1'b0;
      break_ev <= 1'b0;
      low_cnt <= {(DIV_W+4){1'b0}};
    end else begin
      done <= 1'b0;
      start_ev <= 1'b0;
      frame_ev <= 1'b0;
      break_ev <= 1'b0;
      // line-low duration for break detection
      low_cnt <= line ? {(DIV_W+4){1'b0}} : low_cnt + 1'b1;
      case (state)
        ST_IDLE: begin
          // gap counter ends frame once idle time reached
          if (gap_cnt != {IDLE_W{1'b1}})
            gap_cnt <= gap_cnt + 1'b1;
          if (gap_cnt >= idle_cycles)
            in_frame <= 1'b0;
          if (!line && !rate_error) begin
            state <= ST_START;
            bit_cnt <= half_div;
            start_ev <= 1'b1;
            frame_ev <= !in_frame || gap_cnt >= idle_cycles;
          end
        end
        ST_START: begin
          if (bit_cnt == {DIV_W{1'b0}}) begin
            if (line) begin
              state <= ST_IDLE; // glitch, not a real start
            end else begin
              state <= ST_DATA;
              bit_cnt <= bit_div - 1'b1;
              bit_idx <= 4'h0;
              shift <= 9'h000;
              par_acc <= 1'b0;
              done_first <= !in_frame || gap_cnt >= idle_cycles;
              in_frame <= 1'b1;
            end
          end else
            bit_cnt <= bit_cnt - 1'b1;
        end
        ST_DATA: begin
          if (bit_cnt == {DIV_W{1'b0}}) begin
            shift[bit_idx] <= line;
            par_acc <= par_acc ^ line;
            bit_cnt <= bit_div - 1'b1;
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == nbits - 1'b1)
              state <= (parity_mode == `UPTD_PAR_NONE) ? ST_STOP : ST_PAR;
            if (bit_idx == nbits - 1'b1)
              perr <= 1'b0;
          end else
            bit_cnt <= bit_cnt - 1'b1;
        end
        ST_PAR: begin
          if (bit_cnt == {DIV_W{1'b0}}) begin
            // even: data^par must be 0; odd: must be 1
            perr <= (parity_mode == `UPTD_PAR_ODD) ? !(par_acc ^ line) : (par_acc ^ line);
            bit_cnt <= bit_div - 1'b1;
            state <= ST_STOP;
          end else
            bit_cnt <= bit_cnt - 1'b1;
        end
        ST_STOP: begin
          // only the first stop bit is sampled; rest is spacing
          if (bit_cnt == {DIV_W{1'b0}}) begin
            done <= 1'b1;
            done_data <= shift;
            done_perr <= perr;
            done_ferr <= !line;
            gap_cnt <= {IDLE_W{1'b0}};
            state <= line ? ST_IDLE : ST_BRK;
            // extra stop length before hunting the next start
            bit_cnt <= (stop_mode == `UPTD_STOP_1) ? {DIV_W{1'b0}} : stop_len - half_div;
          end else
            bit_cnt <= bit_cnt - 1'b1;
        end
        ST_BRK: begin
          // stop missing: break once low outlasts a whole symbol
          if (low_cnt > sym_cycles && !break_ev && !break_seen)
            break_ev <= 1'b1;
          if (line)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // hold extra stop time before accepting a start
      if (state == ST_IDLE && bit_cnt != {DIV_W{1'b0}}) begin
        bit_cnt <= bit_cnt - 1'b1;
        start_ev <= 1'b0;
        frame_ev <= 1'b0;
        state <= ST_IDLE;
      end
    end
  end

  // symbol index within frame and break sticky until line returns
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sym_idx <= 13'h0000;
      break_seen <= 1'b0;
      frame_active <= 1'b0;
    end else begin
      frame_active <= in_frame;
      if (break_ev)
        break_seen <= 1'b1;
      else if (line)
        break_seen <= 1'b0;
      if (done)
        sym_idx <= done_first ? 13'h0001 : (sym_idx == 13'h1FFF ? sym_idx : sym_idx + 1'b1);
    end
  end
  // zero-based position of the symbol just completed
  wire [12:0] cur_pos = done_first ? 13'h0000 : sym_idx;

  // pattern history and per-symbol match with per-bit care masks
  reg [35:0] hist;
  wire [35:0] hist_now = {hist[26:0], done_data};
  wire [3:0] sym_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_match
      // a symbol slot with no cared bit masks to zero and always matches
      assign sym_hit[g] = (((hist_now[g*9 +: 9] ^ pat_value[g*9 +: 9]) & pat_care[g*9 +: 9]) == 9'h000);
    end
  endgenerate
  wire [2:0] plen = (pat_len == 3'h0) ? 3'h1 : ((pat_len > 3'h4) ? 3'h4 : pat_len);
  // newest symbol sits at slot 0; pattern's first symbol is oldest
  reg pat_ok;
  integer k;
  always @* begin
    pat_ok = 1'b1;
    for (k = 0; k < 4; k = k + 1)
      if (k < plen && !sym_hit[k])
        pat_ok = 1'b0;
  end
  // any-symbol uses the first pattern slot against the newest symbol
  wire any_ok = (((done_data ^ pat_value[8:0]) & pat_care[8:0]) == 9'h000);
  wire [12:0] pat_end = {1'b0, sym_offset} + {10'h000, plen} - 13'h0001;

  // trigger selection, one-cycle pulse
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      trigger <= 1'b0;
      hist <= 36'h000000000;
    end else begin
      if (done)
        hist <= {hist[26:0], done_data};
      case (trig_mode)
        `UPTD_MODE_START: trigger <= start_ev;
        `UPTD_MODE_FRAME: trigger <= frame_ev;
        `UPTD_MODE_FERR: trigger <= done && done_ferr;
        `UPTD_MODE_SYMBOL: trigger <= done && cur_pos == {1'b0, sym_offset};
        `UPTD_MODE_BREAK: trigger <= break_ev;
        `UPTD_MODE_PERR: trigger <= done && done_perr;
        `UPTD_MODE_PATTERN: trigger <= done && cur_pos == pat_end && pat_ok;
        `UPTD_MODE_ANY: trigger <= done && any_ok;
        default: trigger <= 1'b0;
      endcase
    end
  end

  // two-entry skid buffer toward the symbol consumer
  reg [11:0] buf0;
  reg [11:0] buf1;
  reg [1:0] fill;
  wire push = done;
  wire pop = sym_valid && sym_ready;
  assign sym_valid = (fill != 2'h0);
  // full buffer drops the newest symbol; the line cannot be stalled
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      buf0 <= 12'h000;
      buf1 <= 12'h000;
      fill <= 2'h0;
    end else begin
      if (pop) begin
        buf0 <= buf1;
        if (push && fill == 2'h2)
          buf1 <= {done_first, done_ferr, done_perr, done_data};
        else if (push)
          buf0 <= (fill == 2'h1) ? {done_first, done_ferr, done_perr, done_data} : buf1;
        if (!push)
          fill <= fill - 1'b1;
      end else if (push && fill != 2'h2) begin
        if (fill == 2'h0)
          buf0 <= {done_first, done_ferr, done_perr, done_data};
        else
          buf1 <= {done_first, done_ferr, done_perr, done_data};
        fill <= fill + 1'b1;
      end
    end
  end
  // head of buffer presented from flops
  always @* begin
    sym_data = buf0[8:0];
    sym_perr = buf0[9];
    sym_ferr = buf0[10];
    sym_first = buf0[11];
  end
endmodule

/* File: sim/uptd_sva.sv */
// port assertions for the uart trigger decoder
`timescale 1ns/1ps
module uptd_sva #(
  parameter DIV_W = 24
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // configuration
  input wire rate_user,
  input wire [DIV_W-1:0] user_div,
  input wire [3:0] data_bits,
  input wire [1:0] parity_mode,
  // symbol stream
  input wire [8:0] sym_data,
  input wire sym_perr,
  input wire sym_ferr,
  input wire sym_first,
  input wire sym_valid,
  input wire sym_ready,
  // events
  input wire trigger,
  input wire break_seen,
  input wire rate_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // trigger is a single pulse, never stretched
  a_trig_pulse: assert property (trigger |=> !trigger)
    else $error("trigger wider than one cycle");
  a_rate_flag: assert property (rate_error == (rate_user && (user_div < 6 || user_div > 1666666)))
    else $error("rate flag wrong");
  // a bad rate refuses starts, so nothing can come out
  a_rate_quiet: assert property (rate_error [*8] |-> !trigger && !$rose(sym_valid))
    else $error("activity at bad rate");
  // unused high data bits read zero
  a_data_width: assert property (sym_valid |-> (sym_data >> data_bits) == 9'h000)
    else $error("data above width");
  a_no_parity: assert property (sym_valid && parity_mode == 2'h0 |-> !sym_perr)
    else $error("parity error without parity");
  // a stalled head stays put; newer symbols drop once both entries fill
  a_hold_valid: assert property (sym_valid && !sym_ready |=> sym_valid)
    else $error("head dropped");
  a_hold_data: assert property (sym_valid && !sym_ready |=> $stable(sym_data))
    else $error("head data moved");
  a_hold_flags: assert property (sym_valid && !sym_ready |=> $stable({sym_perr, sym_ferr, sym_first}))
    else $error("head flags moved");
  c_trig: cover property (trigger);
  c_perr: cover property (sym_valid && sym_perr);
  c_ferr: cover property (sym_valid && sym_ferr);
  c_brk: cover property ($rose(break_seen));
endmodule

/* File: sim/uptd_tx_model.sv */
// uart transmitter model standing for the observed device
`timescale 1ns/1ps
module uptd_tx_model (
  // clock and request
  input wire clk,
  input wire go,
  input wire [8:0] data,
  // line format
  input wire [3:0] nbits,
  input wire [1:0] par,
  input wire [1:0] stops,
  input wire [23:0] div,
  input wire inv,
  // faults on command
  input wire bad_par,
  input wire brk,
  // line and status
  output wire line,
  output reg busy
);
  reg lv = 1'b1; // logic level, idle is one
  integer i;
  initial busy = 1'b0;
  assign line = lv ^ inv;
  // hold logic value v for n clocks
  task put(input v, input integer n);
    begin
      lv <= v;
      repeat (n) @(posedge clk);
    end
  endtask
  // one symbol per go pulse; a break holds low past a whole symbol
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'b1;
      put(1'b0, brk ? div * (nbits + 4) : div);
      for (i = 0; i < nbits && !brk; i = i + 1)
        put(data[i], div);
      if (par != 2'h0 && !brk)
        put(^(data & ((9'h001 << nbits) - 9'h001)) ^ par[1] ^ bad_par, div);
      put(1'b1, div + (stops == 2'h1 ? div / 2 : stops == 2'h2 ? div : 24'h0));
      busy <= 1'b0;
    end
  end
endmodule

/* File: sim/test_uart_protocol_trigger_decoder.sv */
// self-checking bench for the uart trigger decoder
`timescale 1ns/1ps
`include "uptd_map.vh"
module test_uart_protocol_trigger_decoder;
  reg clk, reset, tx_used, source_tx, polarity_low, rate_user, sym_ready, go, bad_par, brk;
  reg [1:0] parity_mode, stop_mode;
  reg [3:0] data_bits, trig_mode;
  reg [23:0] user_div, idle_cycles, mdiv;
  reg [2:0] preset_sel, pat_len;
  reg [11:0] sym_offset;
  reg [35:0] pat_value, pat_care;
  reg [8:0] mdata, ntrig, nbrk, d;
  reg [2:0] f;
  wire [8:0] sym_data;
  wire sym_perr, sym_ferr, sym_first, sym_valid, trigger, break_seen, frame_active, rate_error, mline, busy;
  integer bad_count, n_checks, cyc, nb, m;
  uptd_tx_model u_tx (.clk(clk), .go(go), .data(mdata), .nbits(data_bits), .par(parity_mode),
    .stops(stop_mode), .div(mdiv), .inv(polarity_low), .bad_par(bad_par), .brk(brk), .line(mline), .busy(busy));
  // unused line rests at idle level
  uptd_decoder DUT (.clk(clk), .reset(reset), .rx_line(source_tx ? ~polarity_low : mline),
    .tx_line(source_tx ? mline : ~polarity_low), .tx_used(tx_used), .source_tx(source_tx),
    .polarity_low(polarity_low), .parity_mode(parity_mode), .stop_mode(stop_mode), .data_bits(data_bits),
    .rate_user(rate_user), .user_div(user_div), .preset_sel(preset_sel), .idle_cycles(idle_cycles),
    .trig_mode(trig_mode), .sym_offset(sym_offset), .pat_len(pat_len), .pat_value(pat_value),
    .pat_care(pat_care), .sym_data(sym_data), .sym_perr(sym_perr), .sym_ferr(sym_ferr),
    .sym_first(sym_first), .sym_valid(sym_valid), .sym_ready(sym_ready), .trigger(trigger),
    .break_seen(break_seen), .frame_active(frame_active), .rate_error(rate_error));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // event counters and hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (trigger === 1'b1) ntrig <= ntrig + 9'h001;
    if (break_seen === 1'b1) nbrk <= nbrk + 9'h001;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end
  task check(input [8:0] seen, input [8:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // one symbol from the model, back when its line idles
  task send(input [8:0] v, input e, input b);
    begin
      {mdata, bad_par, brk, go} <= {v, e, b, 1'b1};
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
    end
  endtask
  // take the buffer head, bounded wait
  task pop;
    integer k;
    begin
      k = 0;
      @(negedge clk);
      while (sym_valid !== 1'b1 && k < 600) begin
        @(negedge clk);
        k = k + 1;
      end
      {d, f} = {sym_data, sym_perr, sym_ferr, sym_first};
      @(posedge clk) sym_ready <= 1'b1;
      @(posedge clk) sym_ready <= 1'b0;
    end
  endtask
  task t_format;
    begin
      for (nb = 5; nb <= 9; nb = nb + 1)
        for (m = 0; m < 3; m = m + 1) begin
          {data_bits, parity_mode, stop_mode, polarity_low, source_tx} <= {nb[3:0], m[1:0], m[1:0], nb[1:0]};
          @(posedge clk);
          send(9'h1A5 ^ nb[8:0], 1'b0, 1'b0);
          pop;
          check(d, (9'h1A5 ^ nb[8:0]) & ((9'h001 << nb) - 9'h001));
          check({7'h00, f[2:1]}, 9'h000);
        end
      $display("format test done");
    end
  endtask
  task t_errors;
    begin
      {trig_mode, parity_mode, ntrig} <= {`UPTD_MODE_PERR, `UPTD_PAR_EVEN, 9'h000};
      send(9'h0F3, 1'b1, 1'b0);
      pop;
      check({8'h00, f[2]}, 9'h001);
      check(ntrig, 9'h001);
      for (m = 0; m < 2; m = m + 1) begin
        {trig_mode, parity_mode, ntrig, nbrk} <= {m ? `UPTD_MODE_FERR : `UPTD_MODE_BREAK, 2'h0, 18'h0};
        send(9'h000, 1'b0, 1'b1);
        pop;
        check({f[1], ntrig[7:0]}, 9'h101);
        check({8'h00, nbrk != 9'h000 && break_seen === 1'b0}, 9'h001);
      end
      $display("error test done");
    end
  endtask
  task t_modes;
    begin
      {data_bits, stop_mode, sym_offset} <= {4'h8, 2'h0, 12'h001};
      for (m = 0; m < 5; m = m + 1) begin
        trig_mode <= (m == 0) ? `UPTD_MODE_START : (m == 1) ? `UPTD_MODE_FRAME : (m == 2) ? `UPTD_MODE_SYMBOL :
          (m == 3) ? `UPTD_MODE_PATTERN : `UPTD_MODE_ANY;
        repeat (60) @(posedge clk);
        check({8'h00, frame_active}, 9'h000);
        ntrig <= 9'h000;
        send(9'h05A, 1'b0, 1'b0);
        send(9'h0C3, 1'b0, 1'b0);
        send(9'h0E7, 1'b0, 1'b0);
        repeat (12) @(posedge clk);
        check(ntrig, m ? 9'h001 : 9'h003);
        check({8'h00, frame_active}, 9'h001);
        pop;
        check({d[7:0], f[0]}, 9'h0B5);
        pop;
        check(d, 9'h0C3);
        @(negedge clk);
        check({8'h00, sym_valid}, 9'h000);
        @(posedge clk);
      end
      $display("mode test done");
    end
  endtask
  task t_rate;
    begin
      {user_div, mdiv, trig_mode, ntrig} <= {24'h5, 24'h5, `UPTD_MODE_START, 9'h000};
      @(posedge clk);
      send(9'h033, 1'b0, 1'b0);
      repeat (20) @(negedge clk);
      check({rate_error, sym_valid, ntrig[6:0]}, 9'h100);
      @(posedge clk);
      {rate_user, preset_sel, user_div, mdiv} <= {1'b0, 3'h7, 24'h8, 24'd250};
      repeat (20) @(posedge clk);
      send(9'h0A6, 1'b0, 1'b0);
      pop;
      check(d, 9'h0A6);
      // tx chosen but not in use: decoding stays on the quiet rx line
      {tx_used, source_tx} <= 2'h1;
      send(9'h05A, 1'b0, 1'b0);
      @(negedge clk);
      check({8'h00, sym_valid}, 9'h000);
      $display("rate test done");
    end
  endtask
  initial begin
    {reset, tx_used, source_tx, polarity_low, rate_user, sym_ready, go, bad_par, brk} = 9'h190;
    {parity_mode, stop_mode, data_bits, trig_mode, preset_sel, pat_len} = {8'h08, 4'h0, 6'h02};
    {user_div, idle_cycles, mdiv, sym_offset} = {24'h8, 24'd40, 24'h8, 12'h000};
    {pat_value, pat_care} = {18'h0, 9'h0C3, 9'h0E2, 18'h0, 9'h1FF, 9'h1F0};
    {mdata, ntrig, nbrk} = 27'h0000000;
    {bad_count, n_checks, cyc} = 96'h0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_format;
    t_errors;
    t_modes;
    t_rate;
    give_verdict;
  end
endmodule
bind uptd_decoder uptd_sva #(.DIV_W(DIV_W)) u_sva (.clk(clk), .reset(reset), .rate_user(rate_user), .user_div(user_div),
  .data_bits(data_bits), .parity_mode(parity_mode), .sym_data(sym_data), .sym_perr(sym_perr),
  .sym_ferr(sym_ferr), .sym_first(sym_first), .sym_valid(sym_valid), .sym_ready(sym_ready),
  .trigger(trigger), .break_seen(break_seen), .rate_error(rate_error));
